// >>> design/serial_svc_defs.svh
// Offsets, field positions, reset values and timing counts
`ifndef SERIAL_SVC_DEFS_SVH
`define SERIAL_SVC_DEFS_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define OFS_CTRL     8'h00
`define OFS_CFG      8'h04
`define OFS_RXLEN    8'h08
`define OFS_RXTMO    8'h0c
`define OFS_RXSTAT   8'h10
`define OFS_CTLSTAT  8'h14
`define OFS_LEFT     8'h18
`define OFS_IRQSTAT  8'h1c
`define OFS_IRQEN    8'h20
`define OFS_IRQCLR   8'h24
// ****************************************
// Control and config field positions
// ****************************************
`define B_RX_REQ     0
`define B_CTL_REQ    1
`define B_RTS_VAL    2
`define B_RTS_EN     3
`define B_DTR_VAL    4
`define B_DTR_EN     5
`define B_BRK        6
`define F_PORT       9:8
`define B_CONF       0
`define B_HAS_MODEM  1
`define F_MODE       3:2
`define MODE_MANUAL  2'h1
`define PORT_LOCAL   2'h0
// ****************************************
// Sizes, resets and timing
// ****************************************
`define Q_DEPTH      11'h400
`define ZERO32       32'h0000_0000
`define CLK_NS       50
`define MS_NS        1000000
`define SIL_NS       10000
`define SIL_CYCLES   (`SIL_NS / `CLK_NS)
`endif

// >>> design/serial_svc_pkg.sv
// Types shared by the serial service block
package serial_svc_pkg;
    typedef enum logic [3:0] {
        OUT_NONE        = 4'h0,
        OUT_BAD_PORT    = 4'h1,
        OUT_PORT_BUSY   = 4'h2,
        OUT_LOCAL_HW    = 4'h3,
        OUT_REMOTE_HW   = 4'h4,
        OUT_BAD_LENGTH  = 4'h5,
        OUT_RX_TIMEOUT  = 4'h6,
        OUT_REFUSED     = 4'h7,
        OUT_NOT_CONFIG  = 4'h8
    } outcome_t;
    typedef enum logic [2:0] {
        OP_IDLE = 3'b001,
        OP_RUN  = 3'b010,
        OP_FIN  = 3'b100
    } op_state_t;
endpackage : serial_svc_pkg

// >>> design/serial_svc.sv
// Extended receive and line control service with APB registers
//
// Contract
// R1: An operation starts only while its request bit is held high.
// R2: Done is high once an operation has fully executed and low at all other times.
// R3: Executing is high while an operation is in progress and low otherwise.
// R4: Failure is shown only together with done, after an operation ended badly.
// R5: A failed operation reports one outcome code from the fixed list.
// R6: Received count lies between zero and the length, and a shortfall is an error.
// R7: After a receive completes the characters left in the queue are reported.
// R8: Line silence is counted in 10 us units from the end of the last queued character.
// R9: Silence refers to this operation's last character only when the leftover count is 0.
// R10: RTS and DTR are driven only on a port that has modem signals.
// R11: Line control runs only in manual modem signal mode, else it is refused.
// R12: RTS and DTR copy their levels only when their write enables are set.
// R13: While break is set the transmit line is held at logic 0.
// R14: At most the requested characters are delivered, the rest stay in the 1024 deep queue.
// R15: A zero timeout returns at once with what is already buffered.
// R16: If the characters do not all arrive before the timeout, the code is receive timeout.
// R17: Done and failure clear when the request is dropped.
`include "serial_svc_defs.svh"
module serial_svc #(
    parameter int MS_CYCLES = `MS_NS / `CLK_NS
) (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RST_N,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Received characters from the UART receiver
    input  wire logic        RX_VALID,
    input  wire logic [7:0]  RX_DATA,
    // Characters delivered to the caller buffer
    output logic             OUT_VALID,
    output logic      [7:0]  OUT_DATA,
    // Line side
    input  wire logic        TX_IN,
    output logic             TXD,
    output logic             RTS,
    output logic             DTR,
    input  wire logic        UART_FAULT,
    input  wire logic        REMOTE_FAULT,
    // Interrupt
    output logic             IRQ
);
    // ****************************************
    // Register file
    // ****************************************
    logic [31:0] ctrl_reg, ctrl_next, cfg_reg, cfg_next, prdata_reg, prdata_next;
    logic [10:0] len_reg, len_next;
    logic [15:0] tmo_reg, tmo_next;
    logic [1:0]  irq_stat_reg, irq_stat_next, irq_en_reg, irq_en_next, irq_set;
    logic        wr_en, rd_setup, hit;
    logic        rx_req, ctl_req;
    logic        rx_irq_set, ct_irq_set;
    logic [31:0] rd_mux;
    // Forward declarations of status read back
    serial_svc_pkg::op_state_t rx_st_reg, rx_st_next, ct_st_reg, ct_st_next;
    serial_svc_pkg::outcome_t  rx_code_reg, rx_code_next, ct_code_reg, ct_code_next;
    logic        rx_err_reg, rx_err_next, ct_err_reg, ct_err_next;
    logic [10:0] rcv_reg, rcv_next, left_reg, left_next;
    logic [15:0] sil_reg, sil_next;

    assign wr_en    = PSEL & PENABLE & PWRITE;
    assign rd_setup = PSEL & ~PENABLE;
    assign rx_req   = ctrl_reg[`B_RX_REQ];
    assign ctl_req  = ctrl_reg[`B_CTL_REQ];
    assign PREADY   = 1'b1;
    assign PSLVERR  = PSEL & PENABLE & ~hit;
    assign PRDATA   = prdata_reg;
    assign IRQ      = |(irq_stat_reg & irq_en_reg);
    assign irq_set  = {ct_irq_set, rx_irq_set};

    always_comb begin
        hit    = 1'b1;
        rd_mux = `ZERO32;
        unique case (PADDR)
            `OFS_CTRL:    rd_mux = ctrl_reg;
            `OFS_CFG:     rd_mux = cfg_reg;
            `OFS_RXLEN:   rd_mux = {21'h0, len_reg};
            `OFS_RXTMO:   rd_mux = {16'h0, tmo_reg};
            `OFS_RXSTAT:  rd_mux = {5'h0, rcv_reg, 8'h0, rx_code_reg, 1'b0, rx_err_reg,
                                    rx_st_reg == serial_svc_pkg::OP_RUN, // R3
                                    rx_st_reg == serial_svc_pkg::OP_FIN}; // R2 R4
            `OFS_CTLSTAT: rd_mux = {24'h0, ct_code_reg, 1'b0, ct_err_reg,
                                    ct_st_reg == serial_svc_pkg::OP_RUN,
                                    ct_st_reg == serial_svc_pkg::OP_FIN};
            `OFS_LEFT:    rd_mux = {sil_reg, 5'h0, left_reg}; // R7 R9
            `OFS_IRQSTAT: rd_mux = {30'h0, irq_stat_reg};
            `OFS_IRQEN:   rd_mux = {30'h0, irq_en_reg};
            `OFS_IRQCLR:  rd_mux = `ZERO32;
            default:      hit = 1'b0;
        endcase
    end

    always_comb begin
        ctrl_next     = ctrl_reg;
        cfg_next      = cfg_reg;
        len_next      = len_reg;
        tmo_next      = tmo_reg;
        irq_en_next   = irq_en_reg;
        prdata_next   = rd_setup & ~PWRITE ? rd_mux : prdata_reg;
        irq_stat_next = irq_stat_reg;
        if (wr_en) begin
            unique case (PADDR)
                `OFS_CTRL:   ctrl_next = PWDATA;
                `OFS_CFG:    cfg_next = PWDATA;
                `OFS_RXLEN:  len_next = PWDATA[10:0];
                `OFS_RXTMO:  tmo_next = PWDATA[15:0];
                `OFS_IRQEN:  irq_en_next = PWDATA[1:0];
                `OFS_IRQCLR: irq_stat_next = irq_stat_reg & ~PWDATA[1:0];
                default: ;
            endcase
        end
        // A completion in the clearing cycle is kept
        irq_stat_next = irq_stat_next | irq_set;
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ctrl_reg     <= `ZERO32;
            cfg_reg      <= `ZERO32;
            len_reg      <= 11'h0;
            tmo_reg      <= 16'h0;
            irq_en_reg   <= 2'h0;
            irq_stat_reg <= 2'h0;
            prdata_reg   <= `ZERO32;
        end else begin
            ctrl_reg     <= ctrl_next;
            cfg_reg      <= cfg_next;
            len_reg      <= len_next;
            tmo_reg      <= tmo_next;
            irq_en_reg   <= irq_en_next;
            irq_stat_reg <= irq_stat_next;
            prdata_reg   <= prdata_next;
        end
    end

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [1:0] uf_sync_reg, rf_sync_reg;
    logic       hw_local, hw_remote;
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            uf_sync_reg <= 2'h0;
            rf_sync_reg <= 2'h0;
        end else begin
            uf_sync_reg <= {uf_sync_reg[0], UART_FAULT};
            rf_sync_reg <= {rf_sync_reg[0], REMOTE_FAULT};
        end
    end
    assign hw_local  = uf_sync_reg[1];
    assign hw_remote = rf_sync_reg[1];

    // ****************************************
    // Receive queue
    // ****************************************
    // Characters arriving while full are dropped; the queue has no back-pressure
    logic [7:0]  mem [`Q_DEPTH];
    logic [9:0]  wp_reg, wp_next, rp_reg, rp_next;
    logic [10:0] qc_reg, qc_next;
    logic        push, pop;
    assign push = RX_VALID & (qc_reg != `Q_DEPTH); // R14
    for (genvar gi = 0; gi < `Q_DEPTH; gi++) begin : g_q
        always_ff @(posedge CLK) begin
            if (!RST_N)
                mem[gi] <= 8'h0;
            else if (push && wp_reg == 10'(gi))
                mem[gi] <= RX_DATA;
        end
    end
    always_comb begin
        wp_next  = wp_reg + 10'(push);
        rp_next  = rp_reg + 10'(pop);
        qc_next  = qc_reg + 11'(push) - 11'(pop);
        sil_next = push ? 16'h0 : sil_reg; // R8
    end

    // ****************************************
    // Silence timer, 10 us ticks
    // ****************************************
    logic [7:0] sdiv_reg, sdiv_next;
    logic       stick;
    assign stick = sdiv_reg == 8'(`SIL_CYCLES - 1);
    always_comb begin
        sdiv_next = push | stick ? 8'h0 : sdiv_reg + 8'h1;
    end
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            wp_reg   <= 10'h0;
            rp_reg   <= 10'h0;
            qc_reg   <= 11'h0;
            sdiv_reg <= 8'h0;
            sil_reg  <= 16'h0;
        end else begin
            wp_reg   <= wp_next;
            rp_reg   <= rp_next;
            qc_reg   <= qc_next;
            sdiv_reg <= sdiv_next;
            // Saturates rather than wrap so long gaps never look short
            sil_reg  <= (!push && stick && sil_reg != 16'hffff) ? sil_reg + 16'h1 : sil_next;
        end
    end

    // ****************************************
    // Extended receive operation
    // ****************************************
    logic [15:0] ms_reg, ms_next;
    logic [14:0] pre_reg, pre_next;
    logic        out_v_next;
    logic [7:0]  out_d_next;
    logic [10:0] rcv_inc;
    assign pop     = rx_st_reg == serial_svc_pkg::OP_RUN && qc_reg != 11'h0
                     && rcv_reg != len_reg; // R14
    assign rcv_inc = rcv_reg + 11'(pop);
    always_comb begin
        rx_st_next   = rx_st_reg;
        rx_code_next = rx_code_reg;
        rx_err_next  = rx_err_reg;
        rcv_next     = rcv_reg;
        left_next    = left_reg;
        pre_next     = pre_reg;
        ms_next      = ms_reg;
        out_v_next   = pop;
        out_d_next   = pop ? mem[rp_reg] : OUT_DATA;
        rx_irq_set   = 1'b0;
        unique case (rx_st_reg)
            serial_svc_pkg::OP_IDLE: begin
                if (rx_req) begin // R1
                    rx_err_next  = 1'b1;
                    rx_st_next   = serial_svc_pkg::OP_FIN;
                    rcv_next     = 11'h0;
                    left_next    = qc_reg;
                    pre_next     = 15'h0;
                    ms_next      = 16'h0;
                    rx_irq_set   = 1'b1;
                    if (!cfg_reg[`B_CONF])
                        rx_code_next = serial_svc_pkg::OUT_NOT_CONFIG; // R5
                    else if (ctrl_reg[`F_PORT] != `PORT_LOCAL)
                        rx_code_next = serial_svc_pkg::OUT_BAD_PORT;
                    else if (hw_local)
                        rx_code_next = serial_svc_pkg::OUT_LOCAL_HW;
                    else if (hw_remote)
                        rx_code_next = serial_svc_pkg::OUT_REMOTE_HW;
                    else if (len_reg == 11'h0 || len_reg > `Q_DEPTH)
                        rx_code_next = serial_svc_pkg::OUT_BAD_LENGTH;
                    else begin
                        rx_err_next  = 1'b0;
                        rx_code_next = serial_svc_pkg::OUT_NONE;
                        rx_st_next   = serial_svc_pkg::OP_RUN;
                        rx_irq_set   = 1'b0;
                    end
                end
            end
            serial_svc_pkg::OP_RUN: begin
                rcv_next = rcv_inc;
                pre_next = pre_reg == 15'(MS_CYCLES - 1) ? 15'h0 : pre_reg + 15'h1;
                ms_next  = pre_reg == 15'(MS_CYCLES - 1) ? ms_reg + 16'h1 : ms_reg;
                if (!rx_req) begin
                    rx_st_next = serial_svc_pkg::OP_IDLE;
                end else if (rcv_inc == len_reg) begin
                    rx_st_next = serial_svc_pkg::OP_FIN;
                    left_next  = qc_next; // R7
                    rx_irq_set = 1'b1;
                end else if ((tmo_reg == 16'h0 && qc_next == 11'h0) // R15
                             || (tmo_reg != 16'h0 && ms_next == tmo_reg)) begin // R16
                    rx_st_next   = serial_svc_pkg::OP_FIN;
                    left_next    = qc_next;
                    rx_err_next  = 1'b1; // R6
                    rx_code_next = serial_svc_pkg::OUT_RX_TIMEOUT;
                    rx_irq_set   = 1'b1;
                end
            end
            serial_svc_pkg::OP_FIN: begin
                if (!rx_req) begin // R17
                    rx_st_next  = serial_svc_pkg::OP_IDLE;
                    rx_err_next = 1'b0;
                end
            end
            default: rx_st_next = serial_svc_pkg::OP_IDLE;
        endcase
    end
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            rx_st_reg   <= serial_svc_pkg::OP_IDLE;
            rx_code_reg <= serial_svc_pkg::OUT_NONE;
            rx_err_reg  <= 1'b0;
            rcv_reg     <= 11'h0;
            left_reg    <= 11'h0;
            pre_reg     <= 15'h0;
            ms_reg      <= 16'h0;
            OUT_VALID   <= 1'b0;
            OUT_DATA    <= 8'h0;
        end else begin
            rx_st_reg   <= rx_st_next;
            rx_code_reg <= rx_code_next;
            rx_err_reg  <= rx_err_next;
            rcv_reg     <= rcv_next;
            left_reg    <= left_next;
            pre_reg     <= pre_next;
            ms_reg      <= ms_next;
            OUT_VALID   <= out_v_next;
            OUT_DATA    <= out_d_next;
        end
    end

    // ****************************************
    // Line control operation
    // ****************************************
    logic rts_next, dtr_next, brk_reg, brk_next, txd_next;
    always_comb begin
        ct_st_next   = ct_st_reg;
        ct_code_next = ct_code_reg;
        ct_err_next  = ct_err_reg;
        rts_next     = RTS;
        dtr_next     = DTR;
        brk_next     = brk_reg;
        txd_next     = brk_reg ? 1'b0 : TX_IN; // R13
        ct_irq_set   = 1'b0;
        unique case (ct_st_reg)
            serial_svc_pkg::OP_IDLE: begin
                if (ctl_req) begin // R1
                    ct_err_next  = 1'b1;
                    ct_st_next   = serial_svc_pkg::OP_FIN;
                    ct_irq_set   = 1'b1;
                    if (!cfg_reg[`B_CONF])
                        ct_code_next = serial_svc_pkg::OUT_NOT_CONFIG;
                    else if (ctrl_reg[`F_PORT] != `PORT_LOCAL)
                        ct_code_next = serial_svc_pkg::OUT_BAD_PORT;
                    else if (hw_local)
                        ct_code_next = serial_svc_pkg::OUT_LOCAL_HW;
                    else if (hw_remote)
                        ct_code_next = serial_svc_pkg::OUT_REMOTE_HW;
                    else if (cfg_reg[`F_MODE] != `MODE_MANUAL)
                        ct_code_next = serial_svc_pkg::OUT_REFUSED; // R11
                    else begin
                        ct_err_next  = 1'b0;
                        ct_code_next = serial_svc_pkg::OUT_NONE;
                        ct_st_next   = serial_svc_pkg::OP_RUN;
                        ct_irq_set   = 1'b0;
                    end
                end
            end
            serial_svc_pkg::OP_RUN: begin
                ct_st_next = ctl_req ? serial_svc_pkg::OP_FIN : serial_svc_pkg::OP_IDLE;
                ct_irq_set = ctl_req;
                if (ctl_req) begin
                    brk_next = ctrl_reg[`B_BRK];
                    if (cfg_reg[`B_HAS_MODEM] && ctrl_reg[`B_RTS_EN]) // R10 R12
                        rts_next = ctrl_reg[`B_RTS_VAL];
                    if (cfg_reg[`B_HAS_MODEM] && ctrl_reg[`B_DTR_EN]) // R10 R12
                        dtr_next = ctrl_reg[`B_DTR_VAL];
                end
            end
            serial_svc_pkg::OP_FIN: begin
                if (!ctl_req) begin // R17
                    ct_st_next  = serial_svc_pkg::OP_IDLE;
                    ct_err_next = 1'b0;
                end
            end
            default: ct_st_next = serial_svc_pkg::OP_IDLE;
        endcase
    end
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ct_st_reg   <= serial_svc_pkg::OP_IDLE;
            ct_code_reg <= serial_svc_pkg::OUT_NONE;
            ct_err_reg  <= 1'b0;
            RTS         <= 1'b0;
            DTR         <= 1'b0;
            brk_reg     <= 1'b0;
            TXD         <= 1'b1;
        end else begin
            ct_st_reg   <= ct_st_next;
            ct_code_reg <= ct_code_next;
            ct_err_reg  <= ct_err_next;
            RTS         <= rts_next;
            DTR         <= dtr_next;
            brk_reg     <= brk_next;
            TXD         <= txd_next;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    logic rx_done, rx_executing_flag;
    assign rx_done = rx_st_reg == serial_svc_pkg::OP_FIN;
    assign rx_executing_flag = rx_st_reg == serial_svc_pkg::OP_RUN;
    a_no_start_idle: assert property ( // R1
        rx_st_reg == serial_svc_pkg::OP_IDLE && !rx_req |=> rx_st_reg == serial_svc_pkg::OP_IDLE)
        else $error("receive left idle without request");
    a_done_executing_flag_excl: assert property (!(rx_done && rx_executing_flag)) // R2 R3
        else $error("done and executing together");
    a_err_with_done: assert property (rx_err_reg |-> rx_done) // R4
        else $error("failure without done");
    a_err_has_code: assert property ( // R5
        rx_done && rx_err_reg |-> rx_code_reg != serial_svc_pkg::OUT_NONE)
        else $error("failure with no outcome code");
    a_short_is_err: assert property (rx_done && rcv_reg < len_reg |-> rx_err_reg) // R6 R14
        else $error("short receive not flagged");
    a_left_report: assert property ($rose(rx_done) && $past(rx_executing_flag) |-> left_reg == qc_reg) // R7
        else $error("leftover count wrong");
    a_silence_reset: assert property (push |=> sil_reg == 16'h0) // R8
        else $error("silence not restarted");
    a_break_line: assert property (brk_reg |=> !TXD) // R13
        else $error("break not holding line low");
    a_rts_keep: assert property ( // R12
        ct_st_reg == serial_svc_pkg::OP_RUN && !ctrl_reg[`B_RTS_EN] |=> $stable(RTS))
        else $error("rts changed without enable");
    a_refuse_mode: assert property ( // R11
        ct_st_reg == serial_svc_pkg::OP_FIN && cfg_reg[`F_MODE] != `MODE_MANUAL
        && $past(ct_st_reg) == serial_svc_pkg::OP_IDLE && cfg_reg[`B_CONF]
        && ctrl_reg[`F_PORT] == `PORT_LOCAL && !hw_local && !hw_remote
        |-> ct_code_reg == serial_svc_pkg::OUT_REFUSED)
        else $error("line control not refused");
    a_req_clear: assert property (rx_done && !rx_req |=> !rx_done ##1 !rx_err_reg) // R17
        else $error("done not cleared");
    c_rx_ok: cover property (rx_executing_flag ##[1:40] rx_done && !rx_err_reg);
    c_rx_tmo: cover property (rx_done && rx_code_reg == serial_svc_pkg::OUT_RX_TIMEOUT);
    c_ctl_ok: cover property (ct_st_reg == serial_svc_pkg::OP_RUN ##1 !ct_err_reg);
    c_irq: cover property ($rose(IRQ));
endmodule : serial_svc

// >>> bench/serial_line_model.sv
// Far side model: received character stream, line level and fault pins
module serial_line_model (
    // Clock
    input  wire logic       CLK,
    // Toward the block
    output logic            RX_VALID = 1'b0,
    output logic      [7:0] RX_DATA = 8'h00,
    output logic            TX_IN = 1'b1,
    output logic            UART_FAULT = 1'b0,
    output logic            REMOTE_FAULT = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] seq_reg = 8'h00;
    // Line keeps moving so a stuck transmit path shows
    always @(posedge CLK) TX_IN <= ~TX_IN;
    // Data is inverted between characters so a stale byte never passes for a fresh one
    task automatic send(input int n, input int gap);
        for (int k = 0; k < n; k++) begin
            @(posedge CLK);
            RX_VALID <= 1'b1;
            RX_DATA <= seq_reg;
            seq_reg <= seq_reg + 8'h01;
            @(posedge CLK);
            RX_VALID <= 1'b0;
            RX_DATA <= ~seq_reg;
            repeat (gap) @(posedge CLK);
        end
    endtask : send
    task automatic fault(input logic l, input logic r);
        UART_FAULT <= l;
        REMOTE_FAULT <= r;
    endtask : fault
endmodule : serial_line_model

// >>> bench/serial_svc_bench.sv
// Self-checking bench for the serial service block
`include "serial_svc_defs.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module serial_svc_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic CLK = 1'b0, RST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00, RX_DATA, OUT_DATA;
    logic [31:0] PWDATA = 32'h0, PRDATA, rd;
    logic PREADY, PSLVERR, RX_VALID, OUT_VALID, TX_IN, TXD, RTS, DTR;
    logic UART_FAULT, REMOTE_FAULT, IRQ, err, er = 1'b0, ed = 1'b0;
    logic [4:0] v;
    logic [7:0] got[$];
    int n_errors = 0, n_checks = 0, n, len, left = 0, nxt = 0, i;
    always #25 CLK = ~CLK;
    always @(posedge CLK) if (OUT_VALID === 1'b1) got.push_back(OUT_DATA);
    serial_svc #(.MS_CYCLES(20)) serial_svc_inst (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .RX_VALID(RX_VALID), .RX_DATA(RX_DATA),
        .OUT_VALID(OUT_VALID), .OUT_DATA(OUT_DATA), .TX_IN(TX_IN), .TXD(TXD), .RTS(RTS),
        .DTR(DTR), .UART_FAULT(UART_FAULT), .REMOTE_FAULT(REMOTE_FAULT), .IRQ(IRQ));
    serial_line_model serial_line_model_inst (.CLK(CLK), .RX_VALID(RX_VALID),
        .RX_DATA(RX_DATA), .TX_IN(TX_IN), .UART_FAULT(UART_FAULT),
        .REMOTE_FAULT(REMOTE_FAULT));
    // ****************************************
    // Expectations and bus tasks
    // ****************************************
    function automatic logic [31:0] stat(serial_svc_pkg::outcome_t c, int cnt);
        return {5'h00, 11'(cnt), 8'h00, c, 1'b0, c != serial_svc_pkg::OUT_NONE, 2'b01};
    endfunction : stat
    function automatic serial_svc_pkg::outcome_t exp_code(int k);
        serial_svc_pkg::outcome_t t[5] = '{serial_svc_pkg::OUT_NOT_CONFIG,
            serial_svc_pkg::OUT_BAD_PORT, serial_svc_pkg::OUT_LOCAL_HW,
            serial_svc_pkg::OUT_REMOTE_HW, serial_svc_pkg::OUT_BAD_LENGTH};
        return t[k];
    endfunction : exp_code
    task automatic test_done;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : test_done
    // Entered just after a rising edge; returns just after one
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        k = 0;
        do begin @(posedge CLK); k++; end while (PREADY !== 1'b1 && k < 50);
        if (k >= 50) begin n_errors++; test_done(); end
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CLK);
    endtask : apb
    task automatic poll(input logic [7:0] a);
        int k;
        for (k = 0; k < 400; k++) begin apb(0, a, 0); if (rd[0] === 1'b1) break; end
        if (k == 400) begin n_errors++; test_done(); end
    endtask : poll
    task automatic rx_run(input int l, input int tmo);
        apb(1, `OFS_RXLEN, l);
        apb(1, `OFS_RXTMO, tmo);
        got.delete();
        apb(1, `OFS_CTRL, 32'h1);
        apb(0, `OFS_RXSTAT, 0);
        `CHK(rd[1] | rd[0], 1'b1)
        poll(`OFS_RXSTAT);
    endtask : rx_run
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        void'($urandom(32'hfdd9));
        repeat (6) @(posedge CLK);
        `CHK({TXD, RTS, DTR, IRQ}, 4'h8)
        RST_N <= 1'b1;
        @(posedge CLK);
        apb(0, 8'h28, 0);
        `CHK({err, rd}, {1'b1, 32'h0})
        apb(1, `OFS_CFG, 32'h0b);
        apb(1, `OFS_IRQEN, 32'h3);
        // Random lengths, leftovers pile up in the queue
        for (i = 0; i < 6; i++) begin
            n = 1 + $urandom % 8;
            len = 1 + $urandom % n;
            serial_line_model_inst.send(n, $urandom % 3);
            rx_run(len, 0);
            `CHK(rd, stat(serial_svc_pkg::OUT_NONE, len))
            repeat (2) @(posedge CLK);
            `CHK(got.size(), len)
            foreach (got[j]) `CHK(got[j], 8'(nxt + j))
            nxt += len;
            left += n - len;
            apb(0, `OFS_LEFT, 0);
            `CHK(rd[10:0], 11'(left))
            `CHK(IRQ, 1'b1)
            apb(1, `OFS_IRQCLR, 32'h3);
            apb(1, `OFS_CTRL, 0);
            apb(0, `OFS_RXSTAT, 0);
            `CHK({IRQ, rd[2:0]}, 4'h0)
        end
        // Shortfall with zero timeout, interrupt masked
        apb(1, `OFS_IRQEN, 0);
        rx_run(left + 3, 0);
        `CHK(rd, stat(serial_svc_pkg::OUT_RX_TIMEOUT, left))
        `CHK(IRQ, 1'b0)
        apb(1, `OFS_IRQEN, 32'h3);
        `CHK(IRQ, 1'b1)
        apb(1, `OFS_CTRL, 0);
        apb(1, `OFS_IRQCLR, 32'h3);
        // Silence after the only queued character
        serial_line_model_inst.send(1, 0);
        rx_run(1, 0);
        apb(1, `OFS_CTRL, 0);
        repeat (450) @(posedge CLK);
        apb(0, `OFS_LEFT, 0);
        `CHK(rd[31:16] inside {[2:3]}, 1'b1)
        rx_run(2, 1);
        `CHK(rd, stat(serial_svc_pkg::OUT_RX_TIMEOUT, 0))
        apb(1, `OFS_CTRL, 0);
        // Refusals in priority order
        for (i = 0; i < 5; i++) begin
            serial_line_model_inst.fault(i == 2, i == 3);
            repeat (3) @(posedge CLK);
            apb(1, `OFS_CFG, i == 0 ? 32'h0 : 32'h0b);
            apb(1, `OFS_RXLEN, i == 4 ? 0 : 1);
            apb(1, `OFS_CTRL, i == 1 ? 32'h101 : 32'h1);
            poll(`OFS_RXSTAT);
            `CHK(rd, stat(exp_code(i), 0))
            apb(1, `OFS_CTRL, 0);
        end
        serial_line_model_inst.fault(1'b0, 1'b0);
        apb(1, `OFS_CFG, 32'h07);
        for (i = 0; i < 6; i++) begin
            v = i == 0 ? 5'h1f : 5'($urandom);
            apb(1, `OFS_CTRL, {v, 2'b10});
            poll(`OFS_CTLSTAT);
            `CHK(rd[7:0], 8'h01)
            if (v[1]) er = v[0];
            if (v[3]) ed = v[2];
            `CHK({RTS, DTR}, {er, ed})
            if (v[4]) `CHK(TXD, 1'b0)
            apb(1, `OFS_CTRL, 0);
        end
        // Automatic mode is refused, no modem pins leaves levels alone
        for (i = 0; i < 2; i++) begin
            apb(1, `OFS_CFG, i == 0 ? 32'h03 : 32'h05);
            apb(1, `OFS_CTRL, {1'b1, ~ed, 1'b1, ~er, 2'b10});
            poll(`OFS_CTLSTAT);
            `CHK({rd[7:0], RTS, DTR}, {i == 0 ? 8'h75 : 8'h01, er, ed})
            apb(1, `OFS_CTRL, 0);
        end
        test_done();
    end
endmodule : serial_svc_bench
